// ---- logic/trapezoidal_closed_loop_drive.sv ----
/*
 * sensorless trapezoidal drive core: commutation, modulation, lead
 * angle, command slew, speed/power PI and PWM generation.
 * assumes zeroCross is a one-cycle pulse from the back-EMF comparator
 * and measurements are synchronous to core_clk.
 */
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module trapezoidal_closed_loop_drive #(
	parameter int CTRL_PWM_PERIODS = 4
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// register port
	input  wire logic [7:0]       regAddr,
	input  wire logic [31:0]      regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic [31:0]           regRdata,
	// motor feedback
	input  wire logic             zeroCross,
	input  wire logic [15:0]      measuredSpeed,
	input  wire logic [15:0]      measured_power,
	input  wire logic [15:0]      bemfDuty,
	// half-bridge drive
	output drive_pkg::gate_t      gateQ
);
	import drive_pkg::*;

	// ========================================
	// register file
	ctrl_reg_t   ctrl_q;
	pair_reg_t   rate_q;
	pair_reg_t   gain_q;
	pair_reg_t   limit_q;
	pair_reg_t   cmd_q;
	pair_reg_t   scale_q;
	logic [31:0] hyst_q;
	logic [31:0] rdata_q;
	logic [31:0] rdNext;
	stat_reg_t   stat;
	pair_reg_t   result;

	wire logic wrCtrl  = regWr && (regAddr == OFF_CTRL);
	wire logic wrRate  = regWr && (regAddr == OFF_RATE);
	wire logic wrGain  = regWr && (regAddr == OFF_GAIN);
	wire logic wrLimit = regWr && (regAddr == OFF_LIMIT);
	wire logic wrCmd   = regWr && (regAddr == OFF_CMD);
	wire logic wrScale = regWr && (regAddr == OFF_SCALE);
	wire logic wrHyst  = regWr && (regAddr == OFF_HYST);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_q  <= ctrl_reg_t'(CTRL_RST);
			rate_q  <= '0;
			gain_q  <= '0;
			limit_q <= pair_reg_t'(LIMIT_RST);
			cmd_q   <= '0;
			scale_q <= pair_reg_t'(SCALE_RST);
			hyst_q  <= '0;
		end else begin
			if (wrCtrl)
				ctrl_q <= ctrl_reg_t'(regWdata & CTRL_WMASK);
			if (wrRate)
				rate_q <= pair_reg_t'(regWdata);
			if (wrGain)
				gain_q <= pair_reg_t'(regWdata);
			if (wrLimit)
				limit_q <= pair_reg_t'(regWdata);
			if (wrCmd)
				cmd_q <= pair_reg_t'(regWdata);
			if (wrScale)
				scale_q <= pair_reg_t'(regWdata);
			if (wrHyst)
				hyst_q <= regWdata & HYST_WMASK;
		end
	end

	assign rdNext = !regRd ? '0 :
		(regAddr == OFF_CTRL)   ? 32'(ctrl_q)  :
		(regAddr == OFF_RATE)   ? 32'(rate_q)  :
		(regAddr == OFF_GAIN)   ? 32'(gain_q)  :
		(regAddr == OFF_LIMIT)  ? 32'(limit_q) :
		(regAddr == OFF_CMD)    ? 32'(cmd_q)   :
		(regAddr == OFF_SCALE)  ? 32'(scale_q) :
		(regAddr == OFF_HYST)   ? hyst_q       :
		(regAddr == OFF_STAT)   ? 32'(stat)    :
		(regAddr == OFF_RESULT) ? 32'(result)  : '0;

	always_ff @(posedge core_clk) begin
		if (!resetn)
			rdata_q <= '0;
		else
			rdata_q <= rdNext;
	end
	assign regRdata = rdata_q;

	// ========================================
	// mode decode
	wire logic isVar   = ctrl_q.commutation_scheme_sel == COMM_VAR;
	wire logic isSpeed = ctrl_q.regTargetSel == TGT_SPEED;
	wire logic isPower = ctrl_q.regTargetSel == TGT_POWER;
	wire logic pwrReg  = ctrl_q.powerStyleSel == PWR_REG;
	wire logic pwrLim  = ctrl_q.powerStyleSel == PWR_LIM;
	wire logic [1:0] effMod = isVar ? MOD_MIX : ctrl_q.modulation_sel;

	// ========================================
	// pwm timebase
	logic [15:0] period_q;
	logic [15:0] pwmCnt_q;
	logic [7:0]  ctrlCnt_q;
	logic [15:0] appliedDuty_q;
	logic [15:0] fade_q;
	logic [6:0]  kc;
	logic [15:0] dutyCyc;
	logic [15:0] fadeCyc;

	assign kc = (ctrl_q.switching_freq_sel < FREQ_MIN_KHZ) ? FREQ_MIN_KHZ :
		(ctrl_q.switching_freq_sel > FREQ_MAX_KHZ) ? FREQ_MAX_KHZ :
		ctrl_q.switching_freq_sel;
	wire logic pwmWrap  = pwmCnt_q >= period_q - 16'h0001;
	wire logic ctrlTick = pwmWrap && (ctrlCnt_q == 8'h00);
	assign dutyCyc = frac(appliedDuty_q, period_q);
	assign fadeCyc = frac(fade_q, period_q);
	wire logic pwmOn  = (pwmCnt_q < dutyCyc) || (appliedDuty_q == DUTY_FULL);
	wire logic fadeOn = pwmCnt_q < fadeCyc;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			period_q  <= '0;
			pwmCnt_q  <= '0;
			ctrlCnt_q <= '0;
		end else begin
			period_q <= CLK_KHZ / {9'h000, kc};
			pwmCnt_q <= pwmWrap ? 16'h0000 : pwmCnt_q + 16'h0001;
			if (ctrlTick)
				ctrlCnt_q <= 8'(CTRL_PWM_PERIODS - 1);
			else if (pwmWrap)
				ctrlCnt_q <= ctrlCnt_q - 8'h01;
		end
	end

	// ========================================
	// command slew
	logic [15:0] ramp_q;
	wire logic [15:0] tgt    = cmd_q.lo;
	wire logic [15:0] accel  = rate_q.lo;
	wire logic [15:0] decel  = rate_q.hi;
	wire logic        surge  = ctrl_q.surge_guard_en;
	wire logic [15:0] upStep = (tgt - ramp_q > accel) ? ramp_q + accel : tgt;
	wire logic [15:0] dnStep = surge ? tgt :
		(ramp_q - tgt > decel) ? ramp_q - decel : tgt;
	wire logic [15:0] rampNext = (tgt > ramp_q) ? upStep : dnStep;

	// ========================================
	// references and pi
	wire logic [15:0] spdRef = frac(ramp_q, scale_q.lo);
	wire logic [15:0] spdMin = frac(cmd_q.hi, scale_q.lo);
	wire logic [15:0] pwrRef = frac(ramp_q, scale_q.hi);
	wire logic [15:0] pwrMin = frac(cmd_q.hi, scale_q.hi);
	wire logic [15:0] speedRef = (spdRef < spdMin) ? spdMin : spdRef;
	wire logic [15:0] powerRef = (pwrRef < pwrMin) ? pwrMin : pwrRef;
	wire logic [15:0] piRef  = isPower ? powerRef : speedRef;
	wire logic [15:0] piMeas = isPower ? measured_power : measuredSpeed;
	wire logic loopOn = isSpeed || isPower;

	logic signed [33:0] integ_q;
	logic signed [16:0] err;
	logic signed [33:0] prop;
	logic signed [33:0] iStep;
	logic signed [33:0] piRaw;
	logic        [15:0] piSat;
	logic [15:0] speed_pi_result_q;
	logic [15:0] power_pi_result_q;

	assign err   = $signed({1'b0, piRef}) - $signed({1'b0, piMeas});
	assign prop  = ($signed({1'b0, gain_q.hi}) * err) >>> GAIN_SHIFT;
	assign iStep = ($signed({1'b0, gain_q.lo}) * err) >>> GAIN_SHIFT;
	assign piRaw = prop + integ_q;
	wire logic satHi = piRaw > $signed({18'h0_0000, limit_q.hi});
	wire logic satLo = piRaw < $signed({18'h0_0000, limit_q.lo});
	assign piSat = satHi ? limit_q.hi : satLo ? limit_q.lo : piRaw[15:0];

	// ========================================
	// applied duty selection
	wire logic overLimit = {1'b0, measured_power} >
		({1'b0, powerRef} + {1'b0, hyst_q[15:0]});
	wire logic usePi = isSpeed || (isPower && (pwrReg || (pwrLim && overLimit)));
	wire logic [15:0] dutySel = usePi ? piSat : ramp_q;
	wire logic guardFloor = surge && (dutySel < bemfDuty);
	wire logic [15:0] dutyNext = guardFloor ? bemfDuty : dutySel;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ramp_q            <= '0;
			integ_q           <= '0;
			appliedDuty_q     <= '0;
			speed_pi_result_q <= '0;
			power_pi_result_q <= '0;
		end else if (ctrlTick) begin
			ramp_q        <= rampNext;
			appliedDuty_q <= dutyNext;
			if (loopOn && !(satHi || satLo))
				integ_q <= integ_q + iStep;
			if (isSpeed)
				speed_pi_result_q <= piSat;
			if (isPower)
				power_pi_result_q <= piSat;
		end
	end

	// ========================================
	// lead angle
	wire logic [9:0] leadMag = {2'h0, ctrl_q.lead_angle_code};
	wire logic [9:0] negClamp = (leadMag > LEAD_NEG_MAX) ? LEAD_NEG_MAX : leadMag;
	wire logic [9:0] varClamp = (leadMag > LEAD_VAR_MAX) ? LEAD_VAR_MAX : leadMag;
	logic signed [10:0] leadEff;
	logic signed [10:0] dlySigned;
	logic        [9:0]  dlyUnits;
	assign leadEff = isVar ?
		(ctrl_q.lead_angle_sign ? $signed({1'b0, varClamp}) : 11'sh000) :
		(ctrl_q.lead_angle_sign ? $signed({1'b0, leadMag}) :
		-$signed({1'b0, negClamp}));
	assign dlySigned = $signed({1'b0, DEG30_UNITS}) - leadEff;
	assign dlyUnits  = dlySigned[10] ? 10'h000 : dlySigned[9:0];

	// ========================================
	// commutation sequencing
	logic [2:0]  commState_q;
	logic [15:0] zcTimer_q;
	logic [15:0] zcPeriod_q;
	logic [15:0] commDly_q;
	logic        armed_q;
	logic        fadeAct_q;
	logic        fadeHi_q;
	phase_t      fadeMask_q;
	logic [15:0] ext_q;
	logic [25:0] dlyProd;
	logic [25:0] extProd;
	logic [9:0]  extU;

	assign dlyProd = zcTimer_q * dlyUnits;
	assign extU = ({2'h0, measuredSpeed[15:8]} > DEG30_UNITS) ?
		DEG30_UNITS : {2'h0, measuredSpeed[15:8]};
	assign extProd = zcPeriod_q * extU;
	wire logic [15:0] extLen = extProd[DEG60_SHIFT +: 16];
	wire logic commAdv = armed_q && (commDly_q == 16'h0000);
	wire logic [2:0] commNext = (commState_q == COMM_LAST) ? 3'h0 :
		commState_q + 3'h1;
	wire phase_t hiMask = HI_TAB[commState_q];
	wire phase_t loMask = LO_TAB[commState_q];
	wire phase_t outMask = (hiMask | loMask) &
		~(HI_TAB[commNext] | LO_TAB[commNext]);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			zcTimer_q  <= '0;
			zcPeriod_q <= '0;
			commDly_q  <= '0;
			armed_q    <= 1'b0;
		end else if (zeroCross) begin
			zcTimer_q  <= '0;
			zcPeriod_q <= zcTimer_q;
			commDly_q  <= dlyProd[DEG60_SHIFT +: 16];
			armed_q    <= 1'b1;
		end else begin
			if (zcTimer_q != 16'hFFFF)
				zcTimer_q <= zcTimer_q + 16'h0001;
			if (commAdv)
				armed_q <= 1'b0;
			else if (armed_q)
				commDly_q <= commDly_q - 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn)
			commState_q <= '0;
		else if (commAdv)
			commState_q <= commNext;
	end

	// variable mode: outgoing phase keeps driving while its duty fades
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fadeAct_q  <= 1'b0;
			fadeHi_q   <= 1'b0;
			fadeMask_q <= '0;
			ext_q      <= '0;
			fade_q     <= '0;
		end else if (commAdv) begin
			fadeAct_q  <= isVar && (extLen != 16'h0000);
			fadeHi_q   <= |(hiMask & outMask);
			fadeMask_q <= outMask;
			ext_q      <= extLen;
			fade_q     <= appliedDuty_q;
		end else if (fadeAct_q) begin
			ext_q <= ext_q - 16'h0001;
			if (ext_q <= 16'h0001)
				fadeAct_q <= 1'b0;
			if (pwmWrap)
				fade_q <= fade_q - (appliedDuty_q >> FADE_SHIFT) > fade_q ?
					16'h0000 : fade_q - (appliedDuty_q >> FADE_SHIFT);
		end
	end

	// ========================================
	// gate drive
	wire logic modLow = (effMod == MOD_LS) ||
		((effMod == MOD_MIX) && commState_q[0]);
	wire phase_t fadeDrv = (fadeAct_q && fadeOn) ? fadeMask_q : 3'h0;
	wire phase_t hsD = (hiMask & {3{modLow || pwmOn}}) |
		(fadeHi_q ? fadeDrv : 3'h0);
	wire phase_t lsD = (loMask & {3{!modLow || pwmOn}}) |
		(fadeHi_q ? 3'h0 : fadeDrv);
	wire phase_t hiZD = ~(hiMask | loMask |
		(fadeAct_q ? fadeMask_q : 3'h0));

	always_ff @(posedge core_clk) begin
		if (!resetn)
			gateQ <= '{hs: 3'h0, ls: 3'h0, hiZ: 3'h7};
		else
			gateQ <= '{hs: hsD, ls: lsD, hiZ: hiZD};
	end

	assign stat = '{appliedDuty: appliedDuty_q, rsvd: '0,
		powerLimiting: isPower && pwrLim && overLimit,
		commState: commState_q};
	assign result = '{hi: power_pi_result_q, lo: speed_pi_result_q};

	// ========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_rise;
		ctrlTick && (tgt > ramp_q);
	endsequence
	sequence s_regTick;
		ctrlTick && isPower && pwrReg && !guardFloor;
	endsequence

	a_state_range: assert property (commState_q <= COMM_LAST)
		else $error("commutation state out of range");
	a_state_step: assert property (commAdv |=> commState_q == $past(commNext))
		else $error("commutation did not step by one");
	a_one_float: assert property ((!isVar && !fadeAct_q) |=>
		$countones(gateQ.hiZ) == 1) else $error("not one floating phase");
	a_hs_mod: assert property ((!isVar && ctrl_q.modulation_sel == MOD_HS)
		|=> (gateQ.ls & $past(loMask)) == $past(loMask))
		else $error("low side not held in high-side mode");
	a_ls_mod: assert property ((!isVar && ctrl_q.modulation_sel == MOD_LS)
		|=> (gateQ.hs & $past(hiMask)) == $past(hiMask))
		else $error("high side not held in low-side mode");
	a_var_mixed: assert property ((isVar && commState_q[0])
		|=> (gateQ.hs & $past(hiMask)) == $past(hiMask))
		else $error("variable mode not mixed");
	a_lead_neg: assert property ((!isVar && !ctrl_q.lead_angle_sign) |->
		leadEff >= -$signed({1'b0, LEAD_NEG_MAX}))
		else $error("negative lead not clamped");
	a_lead_var: assert property (isVar |-> (leadEff >= 0) &&
		(leadEff <= $signed({1'b0, LEAD_VAR_MAX})))
		else $error("variable lead not clamped");
	a_pi_bound: assert property ((limit_q.lo <= limit_q.hi) |->
		(piSat >= limit_q.lo) && (piSat <= limit_q.hi))
		else $error("pi output outside limits");
	a_integ_hold: assert property ((ctrlTick && (satHi || satLo))
		|=> $stable(integ_q)) else $error("integrator ran in saturation");
	a_duty_hold: assert property (!ctrlTick |=> $stable(appliedDuty_q))
		else $error("duty changed off the control tick");
	a_ramp_rate: assert property (s_rise |=>
		(ramp_q - $past(ramp_q)) <= $past(accel))
		else $error("command slewed faster than accel rate");
	a_regulated: assert property (s_regTick |=>
		appliedDuty_q == $past(piSat))
		else $error("regulated power duty not pi output");
endmodule : trapezoidal_closed_loop_drive

// ---- logic/drive_pkg.sv ----
/*
 * constants, register layouts and carriers for the closed-loop
 * trapezoidal drive.
 * assumes a single 20 MHz core clock and a plain register port.
 */
// Function
// - drive 120 degrees, float 60 per half
// - six commutation states per electrical cycle
// - scheme select 00 fixed, 01 variable
// - select 00 chops high side, low on
// - select 01 chops low side, high on
// - select 10 alternates high and low chopping
// - variable mode extends drive, fades, float 30-60
// - modulation select only in fixed mode
// - lead is code times 0.12, sign advances
// - fixed mode clamps delay at -20 degrees
// - variable mode clamps lead 0 to +15
// - speed command slew limited by accel rate
// - speed target select runs PI on speed
// - PI output clamped, integrator frozen when saturated
// - speed ref is duty times full scale, floored
// - power target select, regulated or limit style
// - power ref is duty times full scale, floored
// - power styles share PI gains and limits
// - regulated power applies PI output always; code floors it at bemfDuty when surge guard is on
// - limit style uses PI only above ref+hysteresis
// - power integrator frozen at saturation
// - surge guard on, else decel rate applies
// - switching frequency selectable 5 to 100 kHz
// - commutate from zero crossing on floating phase
package drive_pkg;
	// ========================================
	// timing
	localparam int          CLK_HZ       = 20_000_000;
	localparam logic [15:0] CLK_KHZ      = 16'(CLK_HZ / 1000);
	localparam logic [6:0]  FREQ_MIN_KHZ = 7'h05;
	localparam logic [6:0]  FREQ_MAX_KHZ = 7'h64;
	// ========================================
	// angles in 0.12 degree units
	localparam logic [9:0]  LEAD_NEG_MAX = 10'h0A6;
	localparam logic [9:0]  LEAD_VAR_MAX = 10'h07D;
	localparam logic [9:0]  DEG30_UNITS  = 10'h0FA;
	localparam int          DEG60_SHIFT  = 9;
	localparam int          GAIN_SHIFT   = 8;
	localparam int          FADE_SHIFT   = 2;
	localparam logic [15:0] DUTY_FULL    = 16'hFFFF;
	localparam logic [2:0]  COMM_LAST    = 3'h5;
	// ========================================
	// register map
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_RATE   = 8'h04;
	localparam logic [7:0]  OFF_GAIN   = 8'h08;
	localparam logic [7:0]  OFF_LIMIT  = 8'h0C;
	localparam logic [7:0]  OFF_CMD    = 8'h10;
	localparam logic [7:0]  OFF_SCALE  = 8'h14;
	localparam logic [7:0]  OFF_HYST   = 8'h18;
	localparam logic [7:0]  OFF_STAT   = 8'h1C;
	localparam logic [7:0]  OFF_RESULT = 8'h20;
	localparam logic [31:0] CTRL_WMASK = 32'h7FFF_03FF;
	localparam logic [31:0] HYST_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] CTRL_RST   = 32'h1400_0000;
	localparam logic [31:0] LIMIT_RST  = 32'hFFFF_0000;
	localparam logic [31:0] SCALE_RST  = 32'hFFFF_FFFF;
	// ========================================
	// modes
	typedef enum logic [1:0] {COMM_120 = 2'h0, COMM_VAR = 2'h1} comm_t;
	typedef enum logic [1:0] {
		MOD_HS = 2'h0, MOD_LS = 2'h1, MOD_MIX = 2'h2
	} mod_t;
	typedef enum logic [1:0] {
		TGT_DUTY = 2'h0, TGT_SPEED = 2'h1, TGT_POWER = 2'h2
	} target_t;
	typedef enum logic [1:0] {PWR_REG = 2'h1, PWR_LIM = 2'h2} pwr_t;
	// ========================================
	// commutation table: A=bit0, B=bit1, C=bit2
	typedef logic [2:0] phase_t;
	localparam phase_t HI_TAB [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
	localparam phase_t LO_TAB [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
	// ========================================
	// carriers
	typedef struct packed {
		logic       rsvdHi;
		logic [6:0] switching_freq_sel;
		logic [7:0] lead_angle_code;
		logic [5:0] rsvdLo;
		logic       lead_angle_sign;
		logic       surge_guard_en;
		logic [1:0] powerStyleSel;
		logic [1:0] regTargetSel;
		logic [1:0] modulation_sel;
		logic [1:0] commutation_scheme_sel;
	} ctrl_reg_t;
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} pair_reg_t;
	typedef struct packed {
		logic [15:0] appliedDuty;
		logic [11:0] rsvd;
		logic        powerLimiting;
		logic [2:0]  commState;
	} stat_reg_t;
	typedef struct packed {
		phase_t hs;
		phase_t ls;
		phase_t hiZ;
	} gate_t;

	function automatic logic [15:0] frac(input logic [15:0] a,
		input logic [15:0] b);
		logic [31:0] p;
		p = a * b;
		return p[31:16];
	endfunction : frac
endpackage : drive_pkg

// ---- sim/motor_model.sv ----
/*
 * motor side: zero-crossing pulses every PERIOD cycles, gate watcher.
 * assumes the bench drives run and reads shoot at the end.
 */
`timescale 1ns/1ps
module motor_model #(
	parameter int PERIOD = 400
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// control and gates
	input  wire logic             run,
	input  wire drive_pkg::gate_t gateQ,
	// feedback
	output logic                  zeroCross,
	output logic                  shoot
);
	import drive_pkg::*;
	// ========================================
	// crossing generator
	int cnt;
	always_ff @(posedge core_clk) begin
		if (!resetn || !run) begin
			cnt <= 0;
			zeroCross <= 1'b0;
		end else begin
			zeroCross <= (cnt == PERIOD - 1);
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		end
	end
	// ========================================
	// sticky flag: both fets on, or driven while floating
	always_ff @(posedge core_clk) begin
		if (!resetn)
			shoot <= 1'b0;
		else if ((gateQ.hs & gateQ.ls) != 3'h0 ||
			(gateQ.hiZ & (gateQ.hs | gateQ.ls)) != 3'h0)
			shoot <= 1'b1;
	end
endmodule : motor_model

// ---- sim/trapezoidal_closed_loop_drive_tb_top.sv ----
/*
 * self-checking bench for the trapezoidal drive core.
 * assumes motor_model crossings every 400 cycles, 100 kHz pwm.
 */
`timescale 1ns/1ps
module trapezoidal_closed_loop_drive_tb_top;
	import drive_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic        core_clk, resetn, regWr, regRd, run, zeroCross, shoot;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, v;
	logic [15:0] measuredSpeed, measured_power, bemfDuty;
	gate_t       gateQ;
	int          nMismatch, comparisons, n, h, l;
	logic [2:0]  hiP [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
	logic [2:0]  loP [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
	logic [7:0]  rA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
		8'h18, 8'h3C};
	logic [31:0] rV [8] = '{32'h1400_0000, 0, 0, 32'hFFFF_0000, 0,
		32'hFFFF_FFFF, 0, 0};
	logic [31:0] ldC [5] = '{32'h64FF_0000, 32'h641E_0000, 32'h6464_0200,
		32'h64C8_0201, 32'h6432_0001};
	int          ldD [5] = '{325, 218, 117, 97, 195};
	logic [31:0] mdC [5] = '{32'h6400_0000, 32'h6400_0004, 32'h6400_0008,
		32'h6400_0008, 32'h6400_0001};
	bit          mdH [5] = '{1, 0, 1, 0, 0};

	trapezoidal_closed_loop_drive #(.CTRL_PWM_PERIODS(1)) u_dut (
		.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .zeroCross(zeroCross),
		.measuredSpeed(measuredSpeed), .measured_power(measured_power),
		.bemfDuty(bemfDuty), .gateQ(gateQ));
	motor_model u_motor (.core_clk(core_clk), .resetn(resetn), .run(run),
		.gateQ(gateQ), .zeroCross(zeroCross), .shoot(shoot));

	// ========================================
	// tasks
	task automatic check(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(posedge core_clk);
		d = regRdata;
	endtask : rd
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		rd(a, v);
		check("register", v, e);
	endtask : rdChk
	task automatic dutyChk(input logic [15:0] e);
		rd(OFF_STAT, v);
		check("applied duty", 32'(v[31:16]), 32'(e));
	endtask : dutyChk
	task automatic pollDuty(input logic [15:0] p, e);
		rd(OFF_STAT, v);
		for (int i = 0; i < 150 && v[31:16] === p; i++)
			rd(OFF_STAT, v);
		check("slewed duty", 32'(v[31:16]), 32'(e));
	endtask : pollDuty
	task automatic ticks(input int k);
		repeat (k * 200 + 10) @(posedge core_clk);
	endtask : ticks
	task automatic stepTime(output int c);
		phase_t old;
		@(posedge core_clk iff zeroCross === 1'b1);
		old = gateQ.hiZ;
		c = 0;
		while (gateQ.hiZ === old && c < 4000) begin
			@(posedge core_clk);
			c++;
		end
	endtask : stepTime
	task automatic modChk(input logic [31:0] c, input bit hsChop);
		wr(OFF_CTRL, c);
		repeat (4) @(posedge core_clk);
		h = 0;
		l = 0;
		repeat (200) begin
			@(posedge core_clk);
			if (gateQ.hs !== 3'h0) h++;
			if (gateQ.ls !== 3'h0) l++;
		end
		check("held side", 32'(hsChop ? l : h), 32'h0000_00C8);
		check("chopped side", 32'((hsChop ? h : l) inside {[1:199]}), ONE);
	endtask : modChk
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, nMismatch);
		if (nMismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	// ========================================
	// clock, watchdog
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#(60000 * 50);
		nMismatch++;
		summarize();
	end

	// ========================================
	// tests
	initial begin
		{resetn, regWr, regRd, run, regAddr, regWdata} = '0;
		{measuredSpeed, measured_power, bemfDuty} = '0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) rdChk(rA[i], rV[i]);
		@(posedge core_clk);
		check("read idle", regRdata, 32'h0000_0000);
		wr(OFF_CTRL, 32'hFFFF_FFFF);
		rdChk(OFF_CTRL, 32'h7FFF_03FF);
		wr(OFF_HYST, 32'hFFFF_FFFF);
		rdChk(OFF_HYST, 32'h0000_FFFF);
		wr(8'h3C, 32'hFFFF_FFFF);
		rdChk(8'h3C, 32'h0000_0000);
		wr(OFF_CTRL, 32'h6400_0000);
		wr(OFF_HYST, 32'h0000_0100);
		$display("registers done");
		run <= 1'b1;
		for (int k = 1; k <= 6; k++) begin
			stepTime(n);
			check("low side", 32'(gateQ.ls), 32'(loP[k % 6]));
			check("float", 32'(gateQ.hiZ),
				32'(phase_t'(~(hiP[k % 6] | loP[k % 6]))));
			if (k > 1)
				check("step time", 32'(n inside {[193:200]}), ONE);
		end
		for (int i = 0; i < 5; i++) begin
			wr(OFF_CTRL, ldC[i]);
			stepTime(n);
			stepTime(n);
			check("lead", 32'(n inside {[ldD[i] - 2:ldD[i] + 5]}), ONE);
		end
		run <= 1'b0;
		$display("commutation done");
		wr(OFF_CTRL, 32'h6400_0000);
		wr(OFF_RATE, 32'h0100_1000);
		wr(OFF_CMD, 32'h0000_8000);
		pollDuty(16'h0000, 16'h1000);
		pollDuty(16'h1000, 16'h2000);
		wr(OFF_RATE, 32'h0100_FFFF);
		ticks(2);
		dutyChk(16'h8000);
		for (int i = 0; i < 5; i++) begin
			if (i == 3) begin
				run <= 1'b1;
				stepTime(n);
				run <= 1'b0;
			end
			modChk(mdC[i], mdH[i]);
		end
		$display("modulation done");
		wr(OFF_CTRL, 32'h6400_0010);
		wr(OFF_CMD, 32'h8000_0000);
		wr(OFF_GAIN, 32'h0100_0000);
		wr(OFF_LIMIT, 32'h4000_0100);
		measuredSpeed <= 16'h7000;
		ticks(2);
		dutyChk(16'h0FFF);
		rd(OFF_RESULT, v);
		check("speed result", 32'(v[15:0]), 32'h0000_0FFF);
		measuredSpeed <= 16'h0000;
		ticks(2);
		dutyChk(16'h4000);
		measuredSpeed <= 16'h7F00;
		ticks(2);
		dutyChk(16'h0100);
		measuredSpeed <= 16'h6FFF;
		wr(OFF_LIMIT, 32'h4000_0000);
		wr(OFF_GAIN, 32'h0000_0100);
		ticks(20);
		wr(OFF_GAIN, 32'h0000_0000);
		wr(OFF_LIMIT, 32'hFFFF_0000);
		ticks(2);
		rd(OFF_STAT, v);
		check("windup", 32'(v[31:16] inside {[16'h4000:16'h5000]}), ONE);
		$display("speed loop done");
		wr(OFF_LIMIT, 32'h1000_1000);
		wr(OFF_CMD, 32'h0000_8000);
		wr(OFF_CTRL, 32'h6400_00A0);
		measured_power <= 16'h7000;
		ticks(2);
		dutyChk(16'h8000);
		check("limiting", 32'(v[3]), 32'h0000_0000);
		measured_power <= 16'h9000;
		ticks(2);
		dutyChk(16'h1000);
		check("limiting", 32'(v[3]), ONE);
		wr(OFF_CTRL, 32'h6400_0060);
		measured_power <= 16'h7000;
		ticks(2);
		dutyChk(16'h1000);
		$display("power done");
		wr(OFF_CTRL, 32'h6400_0100);
		bemfDuty <= 16'h3000;
		wr(OFF_CMD, 32'h0000_1000);
		ticks(2);
		dutyChk(16'h3000);
		wr(OFF_CTRL, 32'h6400_0000);
		wr(OFF_CMD, 32'h0000_8000);
		ticks(2);
		wr(OFF_CMD, 32'h0000_1000);
		pollDuty(16'h8000, 16'h7F00);
		check("overlap", 32'(shoot), 32'h0000_0000);
		$display("surge done");
		summarize();
	end
endmodule : trapezoidal_closed_loop_drive_tb_top
